// *** src/cab_cfg.svh ***
`ifndef CAB_CFG_SVH
`define CAB_CFG_SVH

// Data path and register file
`define CAB_DATA_W        8
`define CAB_REG_CNT       32
`define CAB_REG_AW        5
`define CAB_ALL_ONES      8'hff
`define CAB_ZERO_BYTE     8'h00
`define CAB_HALF_BIT      4

// Program counter and relative offsets
`define CAB_PC_W_DEF      9
`define CAB_OFS_W_DEF     12
`define CAB_PC_CALC_W     16
`define CAB_PC_RESET      16'h0000
`define CAB_PC_STEP       16'h0001
`define CAB_PC_SKIP_ONE   16'h0002
`define CAB_PC_SKIP_TWO   16'h0003

// Status word bit positions
`define CAB_FLG_C         0
`define CAB_FLG_Z         1
`define CAB_FLG_N         2
`define CAB_FLG_V         3
`define CAB_FLG_S         4
`define CAB_FLG_H         5
`define CAB_FLG_T         6
`define CAB_FLG_I         7
`define CAB_STATUS_RESET  8'h00

// Cycle counts
`define CAB_CYC_W         2
`define CAB_CYC_ALU       2'h1
`define CAB_CYC_JUMP      2'h2
`define CAB_CYC_CALL      2'h3
`define CAB_CYC_UNTAKEN   2'h1
`define CAB_CYC_TAKEN     2'h2
`define CAB_CYC_SKIP_LONG 2'h3
`define CAB_CYC_ONE       2'h1

`endif

// *** src/cab_pkg.sv ***
package cab_pkg;

    typedef enum logic [4:0] {
        CAB_OP_ADD        = 5'h00,
        CAB_OP_ADC        = 5'h01,
        CAB_OP_SUB        = 5'h02,
        CAB_OP_SBC        = 5'h03,
        CAB_OP_AND        = 5'h04,
        CAB_OP_OR         = 5'h05,
        CAB_OP_EOR        = 5'h06,
        CAB_OP_SETM       = 5'h07,
        CAB_OP_CLRM       = 5'h08,
        CAB_OP_TST        = 5'h09,
        CAB_OP_CP         = 5'h0a,
        CAB_OP_CPC        = 5'h0b,
        CAB_OP_RJMP       = 5'h0c,
        CAB_OP_RELATIVE_SUBROUTINE_ENTRY      = 5'h0d,
        CAB_OP_EQUAL_COMPARE_SKIP       = 5'h0e,
        CAB_OP_SKIP_REG   = 5'h0f,
        CAB_OP_SKIP_IO    = 5'h10,
        CAB_OP_BRANCH     = 5'h11
    } cab_op_t;

    typedef enum logic {
        CAB_COND_FLAG     = 1'b0,
        CAB_COND_SIGNED   = 1'b1
    } cab_cond_t;

    typedef enum logic [1:0] {
        CAB_ST_IDLE       = 2'b00,
        CAB_ST_EXEC       = 2'b01,
        CAB_ST_HOLD       = 2'b10
    } cab_state_t;

    typedef struct packed {
        logic [7:0] res;
        logic       c;
        logic       h;
        logic       v;
    } cab_alu_res_t;

endpackage

// *** src/cab_rf_if.sv ***
`timescale 1ns/1ps
interface cab_rf_if #(
    parameter int AW = 5,
    parameter int DW = 8
);
    logic [AW-1:0] rd_addr_a;
    logic [AW-1:0] rd_addr_b;
    logic [DW-1:0] rd_data_a;
    logic [DW-1:0] rd_data_b;
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;

    modport core (output rd_addr_a, rd_addr_b, wr_en, wr_addr, wr_data, input rd_data_a, rd_data_b);
    modport mem  (input rd_addr_a, rd_addr_b, wr_en, wr_addr, wr_data, output rd_data_a, rd_data_b);
endinterface // cab_rf_if

// *** src/cab_regfile.sv ***
`timescale 1ns/1ps
`include "cab_cfg.svh"
module cab_regfile import cab_pkg::*; #(
    parameter int DEPTH = `CAB_REG_CNT,
    parameter int AW    = `CAB_REG_AW,
    parameter int DW    = `CAB_DATA_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Port side
    cab_rf_if.mem    rf
);
    logic [DW-1:0] mem_ff [DEPTH];
    logic [DW-1:0] rd_a_ff;
    logic [DW-1:0] rd_b_ff;

    // Storage itself carries no reset, like working registers
    always_ff @(posedge ref_clk) begin
        if (rf.wr_en) begin
            mem_ff[rf.wr_addr] <= rf.wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_a_ff <= '0;
            rd_b_ff <= '0;
        end else begin
            rd_a_ff <= mem_ff[rf.rd_addr_a];
            rd_b_ff <= mem_ff[rf.rd_addr_b];
        end
    end

    assign rf.rd_data_a = rd_a_ff;
    assign rf.rd_data_b = rd_b_ff;
endmodule // cab_regfile

// *** src/cab_exec.sv ***
`timescale 1ns/1ps
`include "cab_cfg.svh"
// How it works
// - Add registers, optional carry, six flags, one cycle
// - Subtract register or constant, optional carry, six flags
// - AND/OR/XOR store result, Z N V S only
// - Set-mask ORs, clear-mask ANDs inverted mask
// - Zero-or-minus check ANDs register with itself
// - Relative call: pc+k+1, push return, three cycles
// - Equal-compare skip, one to three cycles, no flags
// - Compares update six flags, write nothing
// - Skip on working register bit low or high
// - Skip on I/O bit low or high
// - Generic flag branch, pc+k+1, one/two cycles
// - Carry, zero, negative branches use plain flag tests
// - Signed branches test N xor V
// - Half-carry branches on H set or clear
// - Transfer-flag branches on T set or clear
// - Overflow branches on V set or clear
// - Interrupt-state branches on I set or clear
module cab_exec import cab_pkg::*; #(
    parameter int PC_W  = `CAB_PC_W_DEF,
    parameter int OFS_W = `CAB_OFS_W_DEF
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // Instruction request
    input  wire logic                 req_valid,
    input  cab_op_t                   req_op,
    input  wire logic                 req_use_imm,
    input  wire logic [4:0]           req_dst,
    input  wire logic [4:0]           req_src,
    input  wire logic [7:0]           req_imm,
    input  wire logic [2:0]           req_bit,
    input  wire logic                 req_want_set,
    input  cab_cond_t                 req_cond,
    input  wire logic [OFS_W-1:0]     req_offset,
    input  wire logic                 req_io_bit,
    input  wire logic                 req_next_two_word,
    // Working register preload
    input  wire logic                 load_en,
    input  wire logic [4:0]           load_addr,
    input  wire logic [7:0]           load_data,
    // Status and program counter preload
    input  wire logic                 flags_load,
    input  wire logic [7:0]           flags_in,
    input  wire logic                 pc_load,
    input  wire logic [PC_W-1:0]      pc_in,
    // Execution results
    output logic                      busy_ff,
    output logic                      done_ff,
    output logic [PC_W-1:0]           pc_ff,
    output logic [7:0]                status_ff,
    output logic [7:0]                result_ff,
    output logic                      push_ff,
    output logic [PC_W-1:0]           push_addr_ff,
    output logic [`CAB_CYC_W-1:0]     cycles_ff
);

    function automatic cab_alu_res_t alu_add(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [8:0] sum;
        logic [4:0] low;
        cab_alu_res_t r;
        sum   = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        r.res = sum[7:0];
        r.c   = sum[8];
        r.h   = low[`CAB_HALF_BIT];
        r.v   = (a[7] & b[7] & ~sum[7]) | (~a[7] & ~b[7] & sum[7]);
        return r;
    endfunction

    // Carry and half carry here are borrows
    function automatic cab_alu_res_t alu_sub(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [8:0] dif;
        logic [4:0] low;
        cab_alu_res_t r;
        dif   = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        low   = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        r.res = dif[7:0];
        r.c   = dif[8];
        r.h   = low[`CAB_HALF_BIT];
        r.v   = (a[7] & ~b[7] & ~dif[7]) | (~a[7] & b[7] & dif[7]);
        return r;
    endfunction

    function automatic logic [`CAB_PC_CALC_W-1:0] sext_ofs(input logic [OFS_W-1:0] ofs);
        return `CAB_PC_CALC_W'(signed'(ofs));
    endfunction

    // Logic ops clear V; S always follows N xor V
    function automatic logic [7:0] upd_flags(input logic [7:0] old, input cab_alu_res_t r,
                                             input logic arith, input logic keep_z);
        logic [7:0] f;
        f = old;
        f[`CAB_FLG_Z] = (r.res == `CAB_ZERO_BYTE) & (~keep_z | old[`CAB_FLG_Z]);
        f[`CAB_FLG_N] = r.res[7];
        f[`CAB_FLG_V] = arith & r.v;
        f[`CAB_FLG_S] = r.res[7] ^ (arith & r.v);
        if (arith) begin
            f[`CAB_FLG_C] = r.c;
            f[`CAB_FLG_H] = r.h;
        end
        return f;
    endfunction

    cab_rf_if #(.AW(`CAB_REG_AW), .DW(`CAB_DATA_W)) rf ();

    cab_regfile #(
        .DEPTH (`CAB_REG_CNT),
        .AW    (`CAB_REG_AW),
        .DW    (`CAB_DATA_W)
    ) u_regs (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .rf      (rf)
    );

    // Latched request
    cab_state_t            state_ff;
    cab_op_t               op_ff;
    cab_cond_t             cond_ff;
    logic                  use_imm_ff;
    logic [4:0]            dst_ff;
    logic [7:0]            imm_ff;
    logic [2:0]            bit_ff;
    logic                  want_set_ff;
    logic [OFS_W-1:0]      ofs_ff;
    logic                  io_bit_ff;
    logic                  two_word_ff;
    logic [`CAB_CYC_W-1:0] rem_ff;

    // Register preload has priority; a request waits while load_en is asserted
    wire                   start     = (state_ff == CAB_ST_IDLE) && req_valid && !load_en;
    wire                   in_exec   = (state_ff == CAB_ST_EXEC);

    // Read data lag one cycle, so addresses come straight from the request
    assign rf.rd_addr_a = req_dst;
    assign rf.rd_addr_b = req_src;

    wire [7:0] opa = rf.rd_data_a;
    wire [7:0] opb = use_imm_ff ? imm_ff : rf.rd_data_b;

    // Operation classes
    wire is_add    = (op_ff == CAB_OP_ADD) || (op_ff == CAB_OP_ADC);
    wire is_sub    = (op_ff == CAB_OP_SUB) || (op_ff == CAB_OP_SBC);
    wire is_cmp    = (op_ff == CAB_OP_CP)  || (op_ff == CAB_OP_CPC);
    wire is_logic  = (op_ff == CAB_OP_AND) || (op_ff == CAB_OP_OR) || (op_ff == CAB_OP_EOR) ||
                     (op_ff == CAB_OP_SETM) || (op_ff == CAB_OP_CLRM) || (op_ff == CAB_OP_TST);
    wire is_skip   = (op_ff == CAB_OP_EQUAL_COMPARE_SKIP) || (op_ff == CAB_OP_SKIP_REG) || (op_ff == CAB_OP_SKIP_IO);
    wire is_branch = (op_ff == CAB_OP_BRANCH);
    wire is_rel    = (op_ff == CAB_OP_RJMP) || (op_ff == CAB_OP_RELATIVE_SUBROUTINE_ENTRY);

    wire old_c     = status_ff[`CAB_FLG_C];
    wire add_cin   = (op_ff == CAB_OP_ADC) & old_c;
    wire sub_cin   = ((op_ff == CAB_OP_SBC) || (op_ff == CAB_OP_CPC)) & old_c;

    cab_alu_res_t add_r;
    cab_alu_res_t sub_r;
    cab_alu_res_t log_r;

    assign add_r = alu_add(opa, opb, add_cin);
    assign sub_r = alu_sub(opa, opb, sub_cin);

    wire [7:0] and_v  = opa & opb;
    wire [7:0] or_v   = opa | opb;
    wire [7:0] xor_v  = opa ^ rf.rd_data_b;
    wire [7:0] setm_v = opa | imm_ff;
    wire [7:0] clrm_v = opa & (`CAB_ALL_ONES - imm_ff);
    wire [7:0] tst_v  = opa & opa;

    wire [7:0] logic_v = (op_ff == CAB_OP_AND)  ? and_v  :
                         (op_ff == CAB_OP_OR)   ? or_v   :
                         (op_ff == CAB_OP_EOR)  ? xor_v  :
                         (op_ff == CAB_OP_SETM) ? setm_v :
                         (op_ff == CAB_OP_CLRM) ? clrm_v : tst_v;

    assign log_r = '{res: logic_v, c: 1'b0, h: 1'b0, v: 1'b0};

    // Compares write nothing
    wire       wr_result = is_add || is_sub || is_logic;
    wire [7:0] alu_res   = is_add ? add_r.res : (is_sub || is_cmp) ? sub_r.res : logic_v;

    // SBC and CPC keep Z only if already set, so multi-byte chains test whole words
    wire       sub_keep_z  = (op_ff == CAB_OP_SBC) || (op_ff == CAB_OP_CPC);
    wire [7:0] arith_flags = upd_flags(status_ff, is_add ? add_r : sub_r, 1'b1, sub_keep_z);
    wire [7:0] logic_flags = upd_flags(status_ff, log_r, 1'b0, 1'b0);

    // Jumps, skips and branches leave the status word alone
    wire [7:0] exec_flags = (is_add || is_sub || is_cmp) ? arith_flags :
                            is_logic                     ? logic_flags : status_ff;

    // Skip conditions
    wire regs_equal  = (opa == rf.rd_data_b);
    wire reg_bit     = opa[bit_ff];
    wire skip_bit    = (op_ff == CAB_OP_SKIP_REG) ? reg_bit : io_bit_ff;
    wire skip_taken  = (op_ff == CAB_OP_EQUAL_COMPARE_SKIP) ? regs_equal : (skip_bit == want_set_ff);

    // Branch condition: any status bit, or the signed relation N xor V
    wire flag_bit    = status_ff[bit_ff];
    wire signed_lt   = status_ff[`CAB_FLG_N] ^ status_ff[`CAB_FLG_V];
    wire cond_val    = (cond_ff == CAB_COND_SIGNED) ? signed_lt : flag_bit;
    // H, T, V and I branches are the generic test on their bit position
    wire br_taken    = (cond_val == want_set_ff);

    // Program counter arithmetic
    wire [`CAB_PC_CALC_W-1:0] pc_wide  = `CAB_PC_CALC_W'(pc_ff);
    wire [`CAB_PC_CALC_W-1:0] pc_rel   = pc_wide + sext_ofs(ofs_ff) + `CAB_PC_STEP;
    wire [`CAB_PC_CALC_W-1:0] pc_next  = pc_wide + `CAB_PC_STEP;
    wire [`CAB_PC_CALC_W-1:0] pc_skip  = pc_wide + (two_word_ff ? `CAB_PC_SKIP_TWO
                                                                : `CAB_PC_SKIP_ONE);

    wire [`CAB_PC_CALC_W-1:0] pc_exec  = is_rel                    ? pc_rel  :
                                         (is_branch && br_taken)   ? pc_rel  :
                                         (is_skip && skip_taken)   ? pc_skip : pc_next;

    // Cycle cost of the instruction in execution
    wire [`CAB_CYC_W-1:0] skip_cyc = !skip_taken ? `CAB_CYC_UNTAKEN :
                                     two_word_ff ? `CAB_CYC_SKIP_LONG : `CAB_CYC_TAKEN;
    wire [`CAB_CYC_W-1:0] exec_cyc = (op_ff == CAB_OP_RELATIVE_SUBROUTINE_ENTRY) ? `CAB_CYC_CALL :
                                     (op_ff == CAB_OP_RJMP)  ? `CAB_CYC_JUMP :
                                     is_skip                 ? skip_cyc      :
                                     is_branch ? (br_taken ? `CAB_CYC_TAKEN
                                                           : `CAB_CYC_UNTAKEN) :
                                     `CAB_CYC_ALU;

    // Register file write: preload while idle, result at the execute edge
    assign rf.wr_en   = in_exec ? wr_result : ((state_ff == CAB_ST_IDLE) && load_en);
    assign rf.wr_addr = in_exec ? dst_ff : load_addr;
    assign rf.wr_data = in_exec ? alu_res : load_data;

    // Sequencer
    cab_state_t            nxt_state;
    logic [`CAB_CYC_W-1:0] nxt_rem;

    always_comb begin
        nxt_state = state_ff;
        nxt_rem   = rem_ff;
        case (state_ff)
            CAB_ST_IDLE: begin
                if (start) begin
                    nxt_state = CAB_ST_EXEC;
                end
            end
            CAB_ST_EXEC: begin
                nxt_rem   = exec_cyc - `CAB_CYC_ONE;
                nxt_state = (exec_cyc == `CAB_CYC_ONE) ? CAB_ST_IDLE : CAB_ST_HOLD;
            end
            CAB_ST_HOLD: begin
                nxt_rem = rem_ff - `CAB_CYC_ONE;
                if (rem_ff == `CAB_CYC_ONE) begin
                    nxt_state = CAB_ST_IDLE;
                end
            end
            default: begin
                nxt_state = CAB_ST_IDLE;
            end
        endcase
    end

    wire finishing = (in_exec && (exec_cyc == `CAB_CYC_ONE)) ||
                     ((state_ff == CAB_ST_HOLD) && (rem_ff == `CAB_CYC_ONE));

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff <= CAB_ST_IDLE;
            rem_ff   <= '0;
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            rem_ff   <= nxt_rem;
            busy_ff  <= (nxt_state != CAB_ST_IDLE);
            done_ff  <= finishing;
        end
    end

    // Request fields are captured once, so the requester may change them while busy
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            op_ff       <= CAB_OP_ADD;
            cond_ff     <= CAB_COND_FLAG;
            use_imm_ff  <= 1'b0;
            dst_ff      <= '0;
            imm_ff      <= '0;
            bit_ff      <= '0;
            want_set_ff <= 1'b0;
            ofs_ff      <= '0;
            io_bit_ff   <= 1'b0;
            two_word_ff <= 1'b0;
        end else if (start) begin
            op_ff       <= req_op;
            cond_ff     <= req_cond;
            use_imm_ff  <= req_use_imm;
            dst_ff      <= req_dst;
            imm_ff      <= req_imm;
            bit_ff      <= req_bit;
            want_set_ff <= req_want_set;
            ofs_ff      <= req_offset;
            io_bit_ff   <= req_io_bit;
            two_word_ff <= req_next_two_word;
        end
    end

    // Architectural state; preloads only act while idle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pc_ff     <= PC_W'(`CAB_PC_RESET);
            status_ff <= `CAB_STATUS_RESET;
        end else if (in_exec) begin
            pc_ff     <= PC_W'(pc_exec);
            status_ff <= exec_flags;
        end else if (state_ff == CAB_ST_IDLE) begin
            if (pc_load) begin
                pc_ff <= pc_in;
            end
            if (flags_load) begin
                status_ff <= flags_in;
            end
        end
    end

    // Result, return-address push and cycle report
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            result_ff    <= '0;
            push_ff      <= 1'b0;
            push_addr_ff <= '0;
            cycles_ff    <= '0;
        end else begin
            push_ff <= in_exec && (op_ff == CAB_OP_RELATIVE_SUBROUTINE_ENTRY);
            if (in_exec) begin
                result_ff    <= alu_res;
                push_addr_ff <= PC_W'(pc_next);
                cycles_ff    <= exec_cyc;
            end
        end
    end

endmodule // cab_exec

// *** test/cab_exec_sva.sv ***
`timescale 1ns/1ps
module cab_exec_sva import cab_pkg::*; #(
    parameter int PC_W  = 9,
    parameter int OFS_W = 12
) (
    // Clock and reset
    input wire logic             ref_clk,
    input wire logic             rst_n,
    // Request
    input wire logic             req_valid,
    input cab_op_t               req_op,
    input wire logic [7:0]       req_imm,
    input wire logic [2:0]       req_bit,
    input wire logic             req_want_set,
    input cab_cond_t             req_cond,
    input wire logic [OFS_W-1:0] req_offset,
    input wire logic             req_io_bit,
    input wire logic             req_next_two_word,
    input wire logic             load_en,
    // Results
    input wire logic             busy_ff,
    input wire logic             done_ff,
    input wire logic [PC_W-1:0]  pc_ff,
    input wire logic [7:0]       status_ff,
    input wire logic [7:0]       result_ff,
    input wire logic             push_ff,
    input wire logic [PC_W-1:0]  push_addr_ff,
    input wire logic [1:0]       cycles_ff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Consequents start two edges after take
    wire            take     = !busy_ff && req_valid && !load_en;
    wire [PC_W-1:0] pc_next  = pc_ff + 1'b1;
    wire [PC_W-1:0] pc_rel   = pc_ff + req_offset[PC_W-1:0] + 1'b1;
    wire [PC_W-1:0] pc_skip  = pc_ff + (req_next_two_word ? 2'h3 : 2'h2);
    wire            sel_bit  = (req_cond == CAB_COND_SIGNED) ? (status_ff[2] ^ status_ff[3]) : status_ff[req_bit];
    wire            flag_hit = (sel_bit == req_want_set);

    sequence s_fin1;
        done_ff && cycles_ff == 2'h1;
    endsequence
    sequence s_fin2;
        !done_ff && cycles_ff == 2'h2 ##1 done_ff;
    endsequence

    a_arith_flags: assert property (
        take && req_op inside {CAB_OP_ADD, CAB_OP_ADC, CAB_OP_SUB, CAB_OP_CP} |-> ##2 status_ff[1] == (result_ff == 8'h00)
        && status_ff[2] == result_ff[7] && status_ff[4] == (status_ff[2] ^ status_ff[3]) ##0 s_fin1)
        else $error("arithmetic flags wrong");
    a_logic_flags: assert property (
        take && req_op inside {CAB_OP_AND, CAB_OP_OR, CAB_OP_EOR, CAB_OP_SETM, CAB_OP_CLRM, CAB_OP_TST} |-> ##2
        !status_ff[3] && status_ff[0] == $past(status_ff[0], 2) && status_ff[1] == (result_ff == 8'h00) ##0 s_fin1)
        else $error("logic flags wrong");
    a_mask_set: assert property (
        take && req_op == CAB_OP_SETM |-> ##2 (result_ff & $past(req_imm, 2)) == $past(req_imm, 2))
        else $error("set mask bits missing");
    a_mask_clear: assert property (
        take && req_op == CAB_OP_CLRM |-> ##2 (result_ff & $past(req_imm, 2)) == 8'h00)
        else $error("clear mask bits left");
    a_call_target: assert property (
        take && req_op == CAB_OP_RELATIVE_SUBROUTINE_ENTRY |-> ##2 pc_ff == $past(pc_rel, 2) && push_ff
        && push_addr_ff == $past(pc_next, 2) && cycles_ff == 2'h3 ##1 !done_ff ##1 done_ff)
        else $error("call target or timing wrong");
    a_branch_taken: assert property (
        take && req_op == CAB_OP_BRANCH && flag_hit |-> ##2 pc_ff == $past(pc_rel, 2) ##0 s_fin2)
        else $error("taken branch wrong");
    a_branch_not: assert property (
        take && req_op == CAB_OP_BRANCH && !flag_hit |-> ##2 pc_ff == $past(pc_next, 2) ##0 s_fin1)
        else $error("untaken branch wrong");
    a_io_skip: assert property (
        take && req_op == CAB_OP_SKIP_IO && req_io_bit == req_want_set |-> ##2 pc_ff == $past(pc_skip, 2)
        && cycles_ff == ($past(req_next_two_word, 2) ? 2'h3 : 2'h2))
        else $error("io skip wrong");
    a_flow_flags: assert property (
        take && req_op inside {CAB_OP_RJMP, CAB_OP_RELATIVE_SUBROUTINE_ENTRY, CAB_OP_EQUAL_COMPARE_SKIP, CAB_OP_SKIP_REG, CAB_OP_SKIP_IO, CAB_OP_BRANCH}
        |-> ##2 status_ff == $past(status_ff, 2))
        else $error("flow op changed flags");
endmodule // cab_exec_sva

bind cab_exec cab_exec_sva #(.PC_W(PC_W), .OFS_W(OFS_W)) u_sva (.*);

// *** test/cab_exec_tb.sv ***
`timescale 1ns/1ps
module cab_exec_tb import cab_pkg::*;;
    logic        ref_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_use_imm = 1'b0, req_want_set = 1'b0;
    logic        req_io_bit = 1'b0, req_next_two_word = 1'b0, load_en = 1'b0, flags_load = 1'b0, pc_load = 1'b0;
    cab_op_t     req_op = CAB_OP_ADD;
    cab_cond_t   req_cond = CAB_COND_FLAG;
    logic [4:0]  req_dst = 5'h00, req_src = 5'h00, load_addr = 5'h00;
    logic [7:0]  req_imm = 8'h00, load_data = 8'h00, flags_in = 8'h00;
    logic [2:0]  req_bit = 3'h0;
    logic [11:0] req_offset = 12'h000;
    logic [8:0]  pc_in = 9'h000;
    logic        busy_ff, done_ff, push_ff;
    logic [8:0]  pc_ff, push_addr_ff;
    logic [7:0]  status_ff, result_ff;
    logic [1:0]  cycles_ff;
    int          error_cnt = 0;
    int          total_checks = 0;

    always #5 ref_clk = ~ref_clk;

    cab_exec #(.PC_W(9), .OFS_W(12)) DUT (.*);

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [8:0] e, g);
        total_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    task automatic setr(input logic [4:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        load_en = 1'b1;
        load_addr = a;
        load_data = d;
        @(negedge ref_clk);
        load_en = 1'b0;
    endtask

    // Flags and pc preloaded per op, so each op is judged on its own
    task automatic ex(input cab_op_t op, input logic [4:0] d, s, input logic [7:0] imm, input logic [2:0] bt,
                      input logic [3:0] f, input logic [11:0] k, input logic [7:0] f_in, input logic [8:0] e_pc,
                      input logic [7:0] e_st, input logic [8:0] e_res, input logic [1:0] e_cyc);
        logic got = 1'b0;
        logic pushed = 1'b0;
        @(negedge ref_clk);
        pc_load = 1'b1;
        pc_in = 9'h100;
        flags_load = 1'b1;
        flags_in = f_in;
        @(negedge ref_clk);
        pc_load = 1'b0;
        flags_load = 1'b0;
        req_op = op;
        {req_dst, req_src, req_imm, req_bit, req_offset} = {d, s, imm, bt, k};
        {req_use_imm, req_want_set, req_io_bit, req_next_two_word} = f;
        req_valid = 1'b1;
        @(negedge ref_clk);
        req_valid = 1'b0;
        chk("busy", 9'h001, {8'h00, busy_ff});
        for (int i = 0; i < 6 && !got; i++) begin
            @(negedge ref_clk);
            pushed |= (push_ff === 1'b1);
            got = (done_ff === 1'b1);
        end
        chk("done", 9'h001, {8'h00, got});
        chk("pc", e_pc, pc_ff);
        chk("status", {1'b0, e_st}, {1'b0, status_ff});
        chk("cycles", {7'h00, e_cyc}, {7'h00, cycles_ff});
        if (!e_res[8]) chk("result", e_res, {1'b0, result_ff});
        chk("push", {8'h00, op == CAB_OP_RELATIVE_SUBROUTINE_ENTRY}, {8'h00, pushed});
        if (op == CAB_OP_RELATIVE_SUBROUTINE_ENTRY) chk("push_addr", 9'h101, push_addr_ff);
        @(negedge ref_clk);
        chk("done_pulse", 9'h000, {8'h00, done_ff});
    endtask

    task automatic alu(input cab_op_t op, input logic [4:0] d, s, input logic [7:0] imm,
                       input logic ui, input logic [7:0] f_in, e_st, input logic [8:0] e_res);
        ex(op, d, s, imm, 3'h0, {ui, 3'h0}, 12'h000, f_in, 9'h101, e_st, e_res, 2'h1);
    endtask

    task automatic flow(input cab_op_t op, input logic [4:0] d, s, input logic [2:0] bt, input logic [3:0] f,
                        input logic [11:0] k, input logic [7:0] st, input logic [8:0] e_pc, input logic [1:0] e_cyc);
        ex(op, d, s, 8'h00, bt, f, k, st, e_pc, st, 9'h100, e_cyc);
    endtask

    task automatic t_arith();
        setr(5'h01, 8'h7f);
        setr(5'h02, 8'h01);
        alu(CAB_OP_ADD, 5'h01, 5'h02, 8'h00, 1'b0, 8'h00, 8'h2c, 9'h080);
        alu(CAB_OP_ADC, 5'h01, 5'h02, 8'h00, 1'b0, 8'h01, 8'h14, 9'h082);
        setr(5'h03, 8'h10);
        alu(CAB_OP_SUB, 5'h03, 5'h00, 8'h01, 1'b1, 8'h00, 8'h20, 9'h00f);
        alu(CAB_OP_TST, 5'h03, 5'h00, 8'h00, 1'b0, 8'h0d, 8'h01, 9'h00f);
        setr(5'h04, 8'h00);
        alu(CAB_OP_SBC, 5'h04, 5'h04, 8'h00, 1'b0, 8'h01, 8'h35, 9'h0ff);
        setr(5'h06, 8'h20);
        setr(5'h07, 8'h20);
        alu(CAB_OP_CP, 5'h06, 5'h07, 8'h00, 1'b0, 8'h35, 8'h02, 9'h100);
        alu(CAB_OP_CP, 5'h06, 5'h00, 8'h21, 1'b1, 8'h00, 8'h35, 9'h100);
        alu(CAB_OP_CPC, 5'h06, 5'h07, 8'h00, 1'b0, 8'h00, 8'h00, 9'h100);
        alu(CAB_OP_TST, 5'h06, 5'h00, 8'h00, 1'b0, 8'h21, 8'h21, 9'h020);
    endtask

    task automatic t_logic();
        setr(5'h04, 8'hf0);
        setr(5'h05, 8'h3c);
        alu(CAB_OP_AND, 5'h04, 5'h05, 8'h00, 1'b0, 8'h09, 8'h01, 9'h030);
        alu(CAB_OP_OR, 5'h04, 5'h05, 8'h00, 1'b0, 8'h08, 8'h00, 9'h03c);
        alu(CAB_OP_EOR, 5'h04, 5'h05, 8'h00, 1'b0, 8'h01, 8'h03, 9'h000);
        alu(CAB_OP_SETM, 5'h04, 5'h00, 8'h81, 1'b1, 8'h01, 8'h15, 9'h081);
        alu(CAB_OP_CLRM, 5'h04, 5'h00, 8'h01, 1'b1, 8'h00, 8'h14, 9'h080);
    endtask

    task automatic t_branch();
        for (int b = 0; b < 8; b++) begin
            flow(CAB_OP_BRANCH, 5'h00, 5'h00, 3'(b), 4'h4, 12'hffe, 8'h01 << b, 9'h0ff, 2'h2);
            flow(CAB_OP_BRANCH, 5'h00, 5'h00, 3'(b), 4'h0, 12'hffe, 8'h01 << b, 9'h101, 2'h1);
            flow(CAB_OP_BRANCH, 5'h00, 5'h00, 3'(b), 4'h0, 12'h00f, ~(8'h01 << b), 9'h110, 2'h2);
        end
        req_cond = CAB_COND_SIGNED;
        flow(CAB_OP_BRANCH, 5'h00, 5'h00, 3'h0, 4'h4, 12'h010, 8'h04, 9'h111, 2'h2);
        flow(CAB_OP_BRANCH, 5'h00, 5'h00, 3'h0, 4'h4, 12'h010, 8'h0c, 9'h101, 2'h1);
        flow(CAB_OP_BRANCH, 5'h00, 5'h00, 3'h0, 4'h0, 12'h010, 8'h0c, 9'h111, 2'h2);
        req_cond = CAB_COND_FLAG;
    endtask

    task automatic t_flow();
        flow(CAB_OP_RJMP, 5'h00, 5'h00, 3'h0, 4'h0, 12'hf00, 8'ha5, 9'h001, 2'h2);
        flow(CAB_OP_RELATIVE_SUBROUTINE_ENTRY, 5'h00, 5'h00, 3'h0, 4'h0, 12'h005, 8'ha5, 9'h106, 2'h3);
        flow(CAB_OP_EQUAL_COMPARE_SKIP, 5'h06, 5'h07, 3'h0, 4'h0, 12'h000, 8'ha5, 9'h102, 2'h2);
        flow(CAB_OP_EQUAL_COMPARE_SKIP, 5'h06, 5'h07, 3'h0, 4'h1, 12'h000, 8'h5a, 9'h103, 2'h3);
        setr(5'h07, 8'h21);
        flow(CAB_OP_EQUAL_COMPARE_SKIP, 5'h06, 5'h07, 3'h0, 4'h0, 12'h000, 8'ha5, 9'h101, 2'h1);
        flow(CAB_OP_SKIP_REG, 5'h04, 5'h00, 3'h7, 4'h0, 12'h000, 8'ha5, 9'h101, 2'h1);
        flow(CAB_OP_SKIP_REG, 5'h04, 5'h00, 3'h7, 4'h4, 12'h000, 8'ha5, 9'h102, 2'h2);
        flow(CAB_OP_SKIP_IO, 5'h00, 5'h00, 3'h0, 4'h1, 12'h000, 8'ha5, 9'h103, 2'h3);
        flow(CAB_OP_SKIP_IO, 5'h00, 5'h00, 3'h0, 4'h2, 12'h000, 8'ha5, 9'h101, 2'h1);
    endtask

    initial begin
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        t_arith();
        t_logic();
        t_branch();
        t_flow();
        stop_test();
    end

    // About sixteen times the expected run
    initial begin
        #50000;
        error_cnt++;
        stop_test();
    end
endmodule // cab_exec_tb
